/* rtl/sld_pkg.sv */
/*
 * Shared constants and types for the serial LCD segment driver logic.
 * Assumes a single 20 MHz clock domain and a word-wide AHB-Lite bus.
 */
package sld_pkg;

   // Shift chain and display geometry.
   localparam int SLD_STAGES = 320;
   localparam int SLD_SEGS = 160;
   localparam int SLD_STATIC_LAST = 159;
   localparam int SLD_DYN_LAST = 319;

   // Common signal dividers, counted in timebase rising edges.
   localparam int SLD_STATIC_DIV = 128;
   localparam int SLD_DYN_DIV = 64;
   localparam logic [5:0] SLD_STATIC_HALF = 6'(SLD_STATIC_DIV / 2 - 1);
   localparam logic [5:0] SLD_DYN_HALF = 6'(SLD_DYN_DIV / 2 - 1);

   // Stand-in for the RC oscillator, derived from the system clock.
   localparam int SLD_CLK_HZ = 20000000;
   localparam int SLD_RC_HZ = 12800;
   localparam logic [9:0] SLD_RC_HALF_CYC =
      10'(SLD_CLK_HZ / (2 * SLD_RC_HZ) - 1);

   // Register map, byte addresses.
   localparam logic [7:0] SLD_CTRL_OFS = 8'h00;
   localparam logic [7:0] SLD_STAT_OFS = 8'h04;

   // Control field positions and reset value.
   localparam int SLD_CTRL_MASTER = 0;
   localparam int SLD_CTRL_DUTY = 1;
   localparam int SLD_CTRL_RCOSC = 2;
   localparam logic [2:0] SLD_CTRL_RST = 3'h5;

   // Status field positions.
   localparam int SLD_STAT_COM = 0;
   localparam int SLD_STAT_SELB = 1;
   localparam int SLD_STAT_SDO = 2;
   localparam int SLD_STAT_LOAD = 3;

   localparam logic [1:0] SLD_HTRANS_NONSEQ = 2'h2;

   // Drive level of a backplane output for the analog stage.
   typedef enum logic [1:0] {
      SLD_LVL_LOW,
      SLD_LVL_HIGH,
      SLD_LVL_MID
   } sld_level_t;

   typedef struct packed {
      logic rc_osc;
      logic half_duty;
      logic master;
   } sld_ctrl_t;

endpackage : sld_pkg

/* rtl/sld_top.sv */
/*
 * Serial LCD segment driver core: shift chain, transparent data latches,
 * common signal generator, backplane and segment phase logic, cascade
 * buffers and a small AHB-Lite register slave for the mode selects.
 * Assumes every display pin is asynchronous to ref_clk and slow enough
 * to be sampled (shift clock well below the 10 MHz Nyquist limit).
 */
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
// Overview of operation
// - Data bit enters stage one and chain shifts on each shift clock rise.
// - Serial data out updates on each falling shift clock edge.
// - Serial data out carries stage 160 in static, 320 in half duty.
// - Display bit high means segment on, low means segment off.
// - Latches follow the chain while load is high and hold when it falls.
// - Master mode generates common timing, slave takes the timebase input.
// - Duty select high picks half duty, low picks static display.
// - Master picks RC or external timebase; slave ignores that select.
// - Master static common reference is timebase divided by 128.
// - Master half duty common reference is timebase divided by 64.
// - Slave uses the timebase input as common and repeats it out.
// - Half duty phase pin is driven by master, read by slave.
// - Static mode holds the phase pin low and never reads it.
// - Shift clock, load, all-on and all-off are repeated for cascading.
// - All-on high forces every segment on, overriding data and all-off.
// - All-off high with all-on low forces every segment off.
// - Static segments use bank A; on drives inverse of common reference.
// - Static mode drives both backplanes in phase with common reference.
// - Half duty backplanes alternate each common cycle; idle one sits mid.
// - Half duty segment uses bank of the selected backplane, inverse if on.
`timescale 1ns/1ps

module sld_top
   import sld_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Serial display interface from host or upstream driver.
   input wire logic serial_data_in,
   input wire logic shift_clock_in,
   input wire logic latch_load_in,
   input wire logic all_on_in,
   input wire logic all_off_in,
   // Timebase and phase alignment pins.
   input wire logic timebase_input,
   input wire logic phase_align_in,
   output logic phase_align_out,
   output logic phase_align_oe_n,
   // Cascade outputs.
   output logic serial_data_out,
   output logic shift_clock_out,
   output logic latch_load_out,
   output logic all_on_out,
   output logic all_off_out,
   output logic common_ref_out,
   // Display drive.
   output sld_level_t backplane_a,
   output sld_level_t backplane_b,
   output logic [SLD_SEGS-1:0] segment_outputs,
   // AHB-Lite register slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);

   typedef struct packed {
      logic [1:0] sdat_s;
      logic [1:0] sclk_s;
      logic [1:0] load_s;
      logic [1:0] on_s;
      logic [1:0] off_s;
      logic [1:0] tb_s;
      logic [1:0] pa_s;
      logic sclk_d;
      logic tb_d;
      logic [SLD_STAGES-1:0] chain;
      logic [SLD_STAGES-1:0] latch;
      logic sdo;
      logic [9:0] rc_cnt;
      logic rc_clk;
      logic rc_d;
      logic [5:0] div_cnt;
      logic com;
      logic com_d;
      logic sel_b;
      sld_ctrl_t ctrl;
      logic wr_pend;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic pa_o;
      logic pa_oe_n;
      logic sclk_o;
      logic load_o;
      logic on_o;
      logic off_o;
      logic com_o;
      sld_level_t bpa;
      sld_level_t bpb;
      logic [SLD_SEGS-1:0] seg;
   } sld_state_t;

   sld_state_t st_r;
   sld_state_t st_nxt;

   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction : rise

   function automatic sld_level_t lvl(input logic b);
      lvl = b ? SLD_LVL_HIGH : SLD_LVL_LOW;
   endfunction : lvl

   function automatic logic [1:0] sync2(input logic [1:0] s, input logic d);
      sync2 = {s[0], d};
   endfunction : sync2

   function automatic logic in_window(input logic [31:0] a);
      in_window = (a[31:8] == 24'h0);
   endfunction : in_window

   function automatic logic shown(input logic data, input logic on,
                                  input logic off);
      if (on)
      begin
         shown = 1'b1;
      end
      else if (off)
      begin
         shown = 1'b0;
      end
      else
      begin
         shown = data;
      end
   endfunction : shown

   function automatic logic [31:0] read_word(input logic [7:0] ofs,
                                             input sld_state_t s);
      read_word = 32'h0;
      if (ofs == SLD_CTRL_OFS)
      begin
         read_word[SLD_CTRL_MASTER] = s.ctrl.master;
         read_word[SLD_CTRL_DUTY] = s.ctrl.half_duty;
         read_word[SLD_CTRL_RCOSC] = s.ctrl.rc_osc;
      end
      else if (ofs == SLD_STAT_OFS)
      begin
         read_word[SLD_STAT_COM] = s.com;
         read_word[SLD_STAT_SELB] = s.sel_b;
         read_word[SLD_STAT_SDO] = s.sdo;
         read_word[SLD_STAT_LOAD] = s.load_s[1];
      end
   endfunction : read_word

   always_comb
   begin
      logic bus_take;
      logic sclk_rise;
      logic sclk_fall;
      logic tick;
      logic [5:0] half;
      logic bit_on;
      bus_take = 1'b0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      tick = 1'b0;
      half = SLD_STATIC_HALF;
      bit_on = 1'b0;
      st_nxt = st_r;

      // Two-stage synchronisers; only the second stage feeds logic.
      st_nxt.sdat_s = sync2(st_r.sdat_s, serial_data_in);
      st_nxt.sclk_s = sync2(st_r.sclk_s, shift_clock_in);
      st_nxt.load_s = sync2(st_r.load_s, latch_load_in);
      st_nxt.on_s = sync2(st_r.on_s, all_on_in);
      st_nxt.off_s = sync2(st_r.off_s, all_off_in);
      st_nxt.tb_s = sync2(st_r.tb_s, timebase_input);
      st_nxt.pa_s = sync2(st_r.pa_s, phase_align_in);
      st_nxt.sclk_d = st_r.sclk_s[1];
      st_nxt.tb_d = st_r.tb_s[1];

      sclk_rise = rise(st_r.sclk_s[1], st_r.sclk_d);
      sclk_fall = rise(st_r.sclk_d, st_r.sclk_s[1]);

      // Data and clock share the same synchroniser depth, so the data
      // seen at the detected edge is the level the host set up.
      if (sclk_rise)
      begin
         st_nxt.chain = {st_r.chain[SLD_STAGES-2:0], st_r.sdat_s[1]};
      end
      if (sclk_fall)
      begin
         st_nxt.sdo = st_r.ctrl.half_duty ? st_r.chain[SLD_DYN_LAST]
                                          : st_r.chain[SLD_STATIC_LAST];
      end

      // Transparent latch: follows the chain while load is high.
      // It takes the next chain value, so a shift and a load agree.
      if (st_r.load_s[1])
      begin
         st_nxt.latch = st_nxt.chain;
      end

      // Free-running stand-in for the RC oscillator. Its rate is fixed at
      // 12804 Hz, near the nominal 12800 Hz, so the common period never drifts as an RC would.
      if (st_r.rc_cnt == SLD_RC_HALF_CYC)
      begin
         st_nxt.rc_cnt = 10'h0;
         st_nxt.rc_clk = ~st_r.rc_clk;
      end
      else
      begin
         st_nxt.rc_cnt = st_r.rc_cnt + 10'h1;
      end
      st_nxt.rc_d = st_r.rc_clk;

      // Common signal generation.
      if (st_r.ctrl.master)
      begin
         tick = st_r.ctrl.rc_osc ? rise(st_r.rc_clk, st_r.rc_d)
                                 : rise(st_r.tb_s[1], st_r.tb_d);
         half = st_r.ctrl.half_duty ? SLD_DYN_HALF : SLD_STATIC_HALF;
         // Greater-or-equal wraps at once when a switch to half duty
         // finds the count already past the shorter limit.
         if (tick)
         begin
            if (st_r.div_cnt >= half)
            begin
               st_nxt.div_cnt = 6'h0;
               st_nxt.com = ~st_r.com;
            end
            else
            begin
               st_nxt.div_cnt = st_r.div_cnt + 6'h1;
            end
         end
      end
      else
      begin
         st_nxt.div_cnt = 6'h0;
         st_nxt.com = st_r.tb_s[1];
      end
      st_nxt.com_d = st_nxt.com;

      // Backplane selection and phase alignment pin.
      if (!st_r.ctrl.half_duty)
      begin
         st_nxt.sel_b = 1'b0;
         st_nxt.pa_o = 1'b0;
         st_nxt.pa_oe_n = 1'b0;
      end
      else if (st_r.ctrl.master)
      begin
         // The selected bank toggles at each common rise and the phase pin shows it.
         if (rise(st_nxt.com, st_r.com_d))
         begin
            st_nxt.sel_b = ~st_r.sel_b;
         end
         st_nxt.pa_o = st_nxt.sel_b;
         st_nxt.pa_oe_n = 1'b0;
      end
      else
      begin
         // A slave follows the synced phase pin, so its backplanes trail
         // the master's by the synchroniser delay.
         st_nxt.sel_b = st_r.pa_s[1];
         st_nxt.pa_o = 1'b0;
         st_nxt.pa_oe_n = 1'b1;
      end

      // Backplane drive levels for the analog stage.
      if (!st_r.ctrl.half_duty)
      begin
         st_nxt.bpa = lvl(st_nxt.com);
         st_nxt.bpb = lvl(st_nxt.com);
      end
      else
      begin
         st_nxt.bpa = st_nxt.sel_b ? SLD_LVL_MID : lvl(st_nxt.com);
         st_nxt.bpb = st_nxt.sel_b ? lvl(st_nxt.com) : SLD_LVL_MID;
      end

      // Segment phase: on drives against the selected common.
      // The overrides read only the second synchroniser stage.
      for (int n = 0; n < SLD_SEGS; n++)
      begin
         if (st_r.ctrl.half_duty && st_nxt.sel_b)
         begin
            bit_on = st_nxt.latch[SLD_SEGS + n];
         end
         else
         begin
            bit_on = st_nxt.latch[n];
         end
         bit_on = shown(bit_on, st_r.on_s[1], st_r.off_s[1]);
         st_nxt.seg[n] = bit_on ^ st_nxt.com;
      end

      // Cascade repeaters, delayed by the synchroniser and one output register.
      st_nxt.sclk_o = st_r.sclk_s[1];
      st_nxt.load_o = st_r.load_s[1];
      st_nxt.on_o = st_r.on_s[1];
      st_nxt.off_o = st_r.off_s[1];
      st_nxt.com_o = st_nxt.com;

      // AHB-Lite slave: zero wait states, always OKAY. Size is not
      // decoded, so a narrow transfer acts as a whole-word one.
      bus_take = hsel && hready && (htrans == SLD_HTRANS_NONSEQ);
      if (st_r.wr_pend)
      begin
         st_nxt.ctrl.master = hwdata[SLD_CTRL_MASTER];
         st_nxt.ctrl.half_duty = hwdata[SLD_CTRL_DUTY];
         st_nxt.ctrl.rc_osc = hwdata[SLD_CTRL_RCOSC];
      end
      st_nxt.wr_pend = bus_take && hwrite && (haddr[7:0] == SLD_CTRL_OFS)
                       && in_window(haddr);
      if (bus_take && !hwrite && in_window(haddr))
      begin
         st_nxt.rdata = read_word(haddr[7:0], st_r);
      end
      else
      begin
         st_nxt.rdata = 32'h0;
      end
      st_nxt.ready = 1'b1;
      st_nxt.resp = 1'b0;
   end

   // Every field but ctrl and ready is cleared. The display pins carry no reset, but clearing
   // the chain and latches keeps the segment outputs defined from the
   // first cycle; the selects come up as a static master on the RC clock.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         st_r <= '0;
         st_r.ctrl <= SLD_CTRL_RST;
         st_r.ready <= 1'b1;
         st_r.bpa <= SLD_LVL_LOW;
         st_r.bpb <= SLD_LVL_LOW;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign serial_data_out = st_r.sdo;
   assign shift_clock_out = st_r.sclk_o;
   assign latch_load_out = st_r.load_o;
   assign all_on_out = st_r.on_o;
   assign all_off_out = st_r.off_o;
   assign common_ref_out = st_r.com_o;
   assign phase_align_out = st_r.pa_o;
   assign phase_align_oe_n = st_r.pa_oe_n;
   assign backplane_a = st_r.bpa;
   assign backplane_b = st_r.bpb;
   assign segment_outputs = st_r.seg;
   assign hrdata = st_r.rdata;
   assign hreadyout = st_r.ready;
   assign hresp = st_r.resp;

endmodule : sld_top

/* verif/sld_host.sv */
/* Host model that shifts display bits and pulses the latch load.
   Assumes a 50 ns ref_clk; the link clock has a 400 ns period. */
`timescale 1ns/1ps
module sld_host
(
   // Clock.
   input wire logic ref_clk,
   // Serial link.
   output logic serial_data_in,
   output logic shift_clock_in,
   output logic latch_load_in
);
   initial
   begin
      serial_data_in = 1'b0;
      shift_clock_in = 1'b0;
      latch_load_in = 1'b0;
   end
   task send(input logic b);
      serial_data_in <= b;
      repeat (4) @(posedge ref_clk);
      shift_clock_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      shift_clock_in <= 1'b0;
   endtask : send
   // The link clock stands low between frames.
   task frame(input logic [319:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
         send(v[i]);
      repeat (4) @(posedge ref_clk);
      // A stale data level is flipped so a late sample cannot pass.
      serial_data_in <= ~serial_data_in;
   endtask : frame
   task latch;
      latch_load_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      latch_load_in <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : latch
endmodule : sld_host

/* verif/sld_top_sva.sv */
/* Port checker for sld_top.
   Assumes display pins are held low while reset is asserted. */
`timescale 1ns/1ps
module sld_top_sva
   import sld_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Pins in.
   input wire logic shift_clock_in,
   input wire logic latch_load_in,
   input wire logic all_on_in,
   input wire logic all_off_in,
   // Pins out.
   input wire logic shift_clock_out,
   input wire logic latch_load_out,
   input wire logic all_on_out,
   input wire logic all_off_out,
   input wire logic serial_data_out,
   input wire logic common_ref_out,
   input sld_level_t backplane_a,
   input sld_level_t backplane_b,
   input wire logic [SLD_SEGS-1:0] segment_outputs
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   property p_clk_out;
      shift_clock_out == $past(shift_clock_in, 3);
   endproperty
   a_clk_out: assert property (p_clk_out)
      else $error("shift clock copy wrong");
   property p_load_out;
      latch_load_out == $past(latch_load_in, 3);
   endproperty
   a_load_out: assert property (p_load_out)
      else $error("load copy wrong");
   property p_test_out;
      {all_on_out, all_off_out} == $past({all_on_in, all_off_in}, 3);
   endproperty
   a_test_out: assert property (p_test_out)
      else $error("test copies wrong");
   property p_sdo_fall;
      $changed(serial_data_out) |-> !shift_clock_in && !$past(shift_clock_in, 2);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall)
      else $error("data out moved off a falling edge");
   property p_bp_pair;
      backplane_a == SLD_LVL_MID |-> backplane_b != SLD_LVL_MID;
   endproperty
   a_bp_pair: assert property (p_bp_pair)
      else $error("both backplanes idle");
   // Outputs may trail the common edge by a cycle, so edges are skipped.
   property p_bp_follow;
      $stable(common_ref_out) && backplane_a != SLD_LVL_MID |->
         backplane_a == (common_ref_out ? SLD_LVL_HIGH : SLD_LVL_LOW);
   endproperty
   a_bp_follow: assert property (p_bp_follow)
      else $error("backplane out of phase");
   property p_all_on;
      all_on_in [*8] ##0 $stable(common_ref_out) |->
         segment_outputs == {SLD_SEGS{~common_ref_out}};
   endproperty
   a_all_on: assert property (p_all_on)
      else $error("all on not shown");
   property p_all_off;
      (!all_on_in && all_off_in) [*8] ##0 $stable(common_ref_out) |->
         segment_outputs == {SLD_SEGS{common_ref_out}};
   endproperty
   a_all_off: assert property (p_all_off)
      else $error("blanking not shown");
endmodule : sld_top_sva

bind sld_top sld_top_sva u_sva (.ref_clk, .rstn, .shift_clock_in,
   .latch_load_in, .all_on_in, .all_off_in, .shift_clock_out,
   .latch_load_out, .all_on_out, .all_off_out, .serial_data_out,
   .common_ref_out, .backplane_a, .backplane_b, .segment_outputs);

/* verif/test_serial_lcd_segment_driver.sv */
/* Self-checking bench for sld_top with a serial host model.
   Assumes the bench drives the timebase at eight ref_clk cycles. */
`timescale 1ns/1ps
module test_serial_lcd_segment_driver
   import sld_pkg::*;
;
   logic ref_clk, rstn, all_on_in, all_off_in, timebase_input, pa_drv;
   logic hsel, hwrite, hready;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic serial_data_in, shift_clock_in, latch_load_in, phase_align_in;
   logic phase_align_out, phase_align_oe_n, serial_data_out;
   logic shift_clock_out, latch_load_out, all_on_out, all_off_out;
   logic common_ref_out, hreadyout, hresp;
   sld_level_t backplane_a, backplane_b, bp_exp;
   logic [SLD_SEGS-1:0] segment_outputs, pa, pb;
   int n_errors, checks_done;
   assign hready = hreadyout;
   // The shared phase wire is ours only while the device lets go.
   assign phase_align_in = phase_align_oe_n ? pa_drv : phase_align_out;
   sld_host u_host (.ref_clk, .serial_data_in, .shift_clock_in,
      .latch_load_in);
   sld_top u_dut (.ref_clk, .rstn, .serial_data_in, .shift_clock_in,
      .latch_load_in, .all_on_in, .all_off_in, .timebase_input,
      .phase_align_in, .phase_align_out, .phase_align_oe_n,
      .serial_data_out, .shift_clock_out, .latch_load_out, .all_on_out,
      .all_off_out, .common_ref_out, .backplane_a, .backplane_b,
      .segment_outputs, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
      .hwdata, .hrdata, .hreadyout, .hresp);
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      timebase_input = 1'b0;
      forever
      begin
         repeat (4) @(posedge ref_clk);
         timebase_input <= ~timebase_input;
      end
   end
   task complete_run;
      if (n_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task chk(input logic [159:0] g, input logic [159:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h", $time, g);
      end
   endtask : chk
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= SLD_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge ref_clk);
      while (!hready) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (!hready) @(posedge ref_clk);
      rd = hrdata;
   endtask : ahb
   task per(input int e);
      time t0;
      repeat (2) @(posedge common_ref_out);
      t0 = $time;
      @(posedge common_ref_out);
      chk(($time - t0) / 50, e);
      @(posedge ref_clk);
   endtask : per
   // Checks are placed away from common edges where outputs may lag.
   task settle;
      repeat (4) @(posedge ref_clk);
      @(common_ref_out);
      repeat (3) @(posedge ref_clk);
   endtask : settle
   task pick(input logic b);
      wait ((b ? backplane_a : backplane_b) != SLD_LVL_MID);
      wait ((b ? backplane_a : backplane_b) == SLD_LVL_MID);
      repeat (2) @(posedge ref_clk);
   endtask : pick
   initial
   begin
      #3000000;
      n_errors++;
      complete_run();
   end
   initial
   begin
      {rstn, all_on_in, all_off_in, pa_drv, hsel, hwrite} = 6'h0;
      {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
      n_errors = 0;
      checks_done = 0;
      pa = {5{32'hc3a5_0f96}};
      pb = {5{32'h5a3c_e1d2}};
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      ahb(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h5);
      chk(hresp, 1'b0);
      ahb(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h0, 32'h1);
      per(1024);
      u_host.frame({160'h0, pa}, 160);
      u_host.latch();
      u_host.frame(320'h0, 8);
      settle();
      chk(segment_outputs, pa ^ {160{common_ref_out}});
      chk(serial_data_out, pa[151]);
      bp_exp = common_ref_out ? SLD_LVL_HIGH : SLD_LVL_LOW;
      chk({backplane_a, backplane_b}, {bp_exp, bp_exp});
      chk({phase_align_oe_n, phase_align_out}, 2'h0);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd & 32'hffff_fffe, {28'h0, 1'b0, pa[151], 2'h0});
      all_on_in <= 1'b1;
      all_off_in <= 1'b1;
      settle();
      chk(segment_outputs, ~{160{common_ref_out}});
      all_on_in <= 1'b0;
      settle();
      chk(segment_outputs, {160{common_ref_out}});
      all_off_in <= 1'b0;
      ahb(1'b1, 32'h0, 32'h3);
      per(512);
      u_host.frame({pb, pa}, 320);
      u_host.latch();
      pick(1'b1);
      chk(segment_outputs, pb ^ {160{common_ref_out}});
      chk({phase_align_oe_n, phase_align_out}, 2'h1);
      pick(1'b0);
      chk(segment_outputs, pa ^ {160{common_ref_out}});
      chk(serial_data_out, pb[159]);
      ahb(1'b1, 32'h0, 32'h6);
      per(8);
      pa_drv <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk({phase_align_oe_n, backplane_a}, {1'b1, SLD_LVL_MID});
      pa_drv <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(backplane_b, SLD_LVL_MID);
      complete_run();
   end
endmodule : test_serial_lcd_segment_driver
